/* File: rtl/uoc_pkg.sv */
/*
 * Shared constants for the USB on-the-go control and status register block.
 * Assumes a 32-bit classic Wishbone master and byte addresses in the low 16 bits.
 */
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Link control bit 7 reads the live J-state flag from the receiver.
// - Link control bit 6 reads the live single-ended-zero flag.
// - Device mode: bit 5 disables packet processing, set by hardware on SETUP.
// - Host mode: bit 5 reads one while a token is in execution.
// - Host mode: bit 4 drives bus reset while one, ends it when zero.
// - Bit 3 enables host capability; any change resets host control logic.
// - Bit 2 drives resume signalling while one, none while zero.
// - Host mode: clearing resume appends a low-speed end-of-packet.
// - Registers have clear, set, invert aliases at plus 0x4, 0x8, 0xc.
// - Bus interrupt and bus error flags decode only the base address and the clear alias.
// - Transfer status has no aliases; only its base address decodes.
// - Activity pending is undefined after reset; all else resets to zero.
// - Control bits 31 to 8 read zero and ignore writes.
//////////////////////////////////////////////////////////////////////////////
package uoc_pkg;
	localparam int          UOC_NREG   = 13;
	localparam int          UOC_ADDR_W = 16;
	localparam int          UOC_REG_W  = 8;

	typedef enum logic [1:0] {
		UOC_AL_BASE = 2'h0,
		UOC_AL_CLR  = 2'h1,
		UOC_AL_SET  = 2'h2,
		UOC_AL_INV  = 2'h3
	} uoc_alias_t;

	localparam int IDX_OTG_IF   = 0;
	localparam int IDX_OTG_IE   = 1;
	localparam int IDX_OTG_STAT = 2;
	localparam int IDX_OTG_CON  = 3;
	localparam int IDX_PWR      = 4;
	localparam int IDX_BUS_IF   = 5;
	localparam int IDX_BUS_IE   = 6;
	localparam int IDX_ERR_IF   = 7;
	localparam int IDX_ERR_IE   = 8;
	localparam int IDX_XSTAT    = 9;
	localparam int IDX_LINK     = 10;
	localparam int IDX_FADDR    = 11;
	localparam int IDX_BDT      = 12;

	localparam logic [15:0] REG_OFS [UOC_NREG] = '{
		16'h5040, 16'h5050, 16'h5060, 16'h5070, 16'h5080, 16'h5200, 16'h5210,
		16'h5220, 16'h5230, 16'h5240, 16'h5250, 16'h5260, 16'h5270};
	localparam logic [7:0] WMASK [UOC_NREG] = '{
		8'hfd, 8'hfd, 8'h00, 8'hff, 8'h93, 8'hff, 8'hff,
		8'hff, 8'hff, 8'h00, 8'h3f, 8'hff, 8'hfe};
	localparam logic [3:0] ALIAS_OK [UOC_NREG] = '{
		4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h3, 4'hf,
		4'h3, 4'hf, 4'h1, 4'hf, 4'hf, 4'hf};
	localparam logic [UOC_NREG-1:0] W1C_REGS = 13'h00a1;
	localparam logic [7:0] NORST_PWR = 8'h80;

	localparam int CTL_ENABLE = 0;
	localparam int CTL_PPRST  = 1;
	localparam int CTL_RESUME = 2;
	localparam int CTL_HOST_ON  = 3;
	localparam int CTL_BUSRST   = 4;
	localparam int CTL_PKT_HALT = 5;
	localparam int CTL_LINE_ZERO = 6;
	localparam int CTL_LINE_J    = 7;
	localparam int PWR_BUSY   = 3;
	localparam int PWR_ACTPND = 7;
	localparam int ALIAS_LSB  = 2;
	localparam int BASE_LSB   = 4;
endpackage : uoc_pkg

/* File: rtl/uoc_ctrl.sv */
/*
 * USB on-the-go control and status registers behind a classic Wishbone slave.
 * Assumes line flags, events and status words arrive synchronous to clk_i.
 */
`timescale 1ns/100ps
module uoc_ctrl (
	input  wire logic                        clk_i,            // 25 MHz clock
	input  wire logic                        rst_i,            // Sync reset, high
	input  wire logic                        wb_cyc_i,         // Bus cycle
	input  wire logic                        wb_stb_i,         // Strobe
	input  wire logic                        wb_we_i,          // Write enable
	input  wire logic [uoc_pkg::UOC_ADDR_W-1:0] wb_adr_i,      // Byte address
	input  wire logic [3:0]                  wb_sel_i,         // Byte selects
	input  wire logic [31:0]                 wb_dat_i,         // Write data
	output logic      [31:0]                 wb_dat_o,         // Read data
	output logic                             wb_ack_o,         // Acknowledge
	input  wire logic                        live_j_line_flag_i,            // J state
	input  wire logic                        live_single_ended_zero_flag_i, // SE0
	input  wire logic                        setup_token_i,    // SETUP seen, pulse
	input  wire logic                        token_in_execution_i, // Token busy
	input  wire logic [7:0]                  otg_line_state_i, // OTG status word
	input  wire logic [7:0]                  otg_event_i,      // OTG events
	input  wire logic [7:0]                  bus_event_i,      // Bus events
	input  wire logic [7:0]                  bus_error_event_i, // Error events
	input  wire logic [7:0]                  transfer_status_i, // Transfer status
	input  wire logic                        suspend_busy_i,   // Power busy
	input  wire logic                        activity_i,       // Bus activity
	output logic                             irq_o,            // Interrupt level
	output logic                             module_enable_o,  // Enable or frame start
	output logic                             ping_pong_reset_o, // Buffer pointer reset
	output logic                             resume_drive_o,   // Drive resume
	output logic                             resume_eop_o,     // Append EOP, pulse
	output logic                             host_capability_enable_o, // Host mode
	output logic                             host_logic_reset_o, // Host reset, pulse
	output logic                             bus_reset_drive_o, // Drive bus reset
	output logic                             packet_processing_disable_o, // Halt
	output logic      [7:0]                  otg_pull_and_vbus_o, // Pull control
	output logic      [7:0]                  power_control_o,  // Power control
	output logic      [7:0]                  function_address_o, // Address
	output logic      [7:0]                  descriptor_page_o // Table page
);
	import uoc_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// Address decode and alias arithmetic.

	function automatic logic [4:0] uoc_decode(input logic [UOC_ADDR_W-1:0] adr);
		logic [4:0] r;
		logic [1:0] k;
		r = 5'h00;
		k = adr[ALIAS_LSB +: 2];
		for (int i = 0; i < UOC_NREG; i++) begin
			if (adr[1:0] == 2'h0 && {adr[UOC_ADDR_W-1:BASE_LSB], 4'h0} == REG_OFS[i]
				&& ALIAS_OK[i][k]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : uoc_decode

	function automatic logic [7:0] uoc_apply(input logic [7:0] q, input logic [7:0] d,
		input logic [1:0] k, input logic w1c);
		logic [7:0] r;
		r = q;
		case (k)
			UOC_AL_BASE: r = w1c ? (q & ~d) : d;
			UOC_AL_CLR:  r = q & ~d;
			UOC_AL_SET:  r = q | d;
			UOC_AL_INV:  r = q ^ d;
			default:     r = q;
		endcase
		return r;
	endfunction : uoc_apply

	logic [4:0] dec;
	logic       hit;
	logic [3:0] idx;
	logic [1:0] kind;
	logic       ack_q;
	logic       wr_now;
	logic [31:0] dat_q;
	logic [7:0] regs_q [UOC_NREG];
	logic [7:0] hw_set [UOC_NREG];
	logic [7:0] rd_val;
	logic       host_on_prev_q;
	logic       resume_prev_q;
	logic       host_rst_q;
	logic       eop_q;

	assign dec    = uoc_decode(wb_adr_i);
	assign hit    = dec[4];
	assign idx    = dec[3:0];
	assign kind   = wb_adr_i[ALIAS_LSB +: 2];
	assign wr_now = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & hit & wb_sel_i[0];

	//////////////////////////////////////////////////////////////////////////
	// Bus handshake: ack one cycle after the request, data registered with it.

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
		end
	end

	always_comb begin
		rd_val = 8'h00;
		if (hit) begin
			case (idx)
				4'(IDX_OTG_STAT): rd_val = otg_line_state_i;
				4'(IDX_XSTAT):    rd_val = transfer_status_i;
				4'(IDX_PWR): begin
					rd_val = regs_q[IDX_PWR];
					rd_val[PWR_BUSY] = suspend_busy_i;
				end
				4'(IDX_LINK): begin
					rd_val = regs_q[IDX_LINK];
					rd_val[CTL_LINE_J] = live_j_line_flag_i;
					rd_val[CTL_LINE_ZERO] = live_single_ended_zero_flag_i;
					if (regs_q[IDX_LINK][CTL_HOST_ON]) begin
						rd_val[CTL_PKT_HALT] = token_in_execution_i;
					end
				end
				default: rd_val = regs_q[idx];
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
			dat_q <= {24'h00_0000, rd_val};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Hardware events; a set in the clearing cycle wins.

	always_comb begin
		for (int i = 0; i < UOC_NREG; i++) begin
			hw_set[i] = 8'h00;
		end
		hw_set[IDX_OTG_IF] = otg_event_i & WMASK[IDX_OTG_IF];
		hw_set[IDX_BUS_IF] = bus_event_i;
		hw_set[IDX_ERR_IF] = bus_error_event_i;
		hw_set[IDX_PWR][PWR_ACTPND] = activity_i;
		hw_set[IDX_LINK][CTL_PKT_HALT] = setup_token_i & ~regs_q[IDX_LINK][CTL_HOST_ON];
	end

	for (genvar g = 0; g < UOC_NREG; g++) begin : g_reg
		logic [7:0] next_w;
		assign next_w = (uoc_apply(regs_q[g], wb_dat_i[7:0] & WMASK[g], kind, W1C_REGS[g])
			& WMASK[g]) | (regs_q[g] & ~WMASK[g]);
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				regs_q[g] <= (g == IDX_PWR) ? (regs_q[g] & NORST_PWR) : 8'h00;
			end else if (wr_now && idx == 4'(g)) begin
				regs_q[g] <= next_w | hw_set[g];
			end else begin
				regs_q[g] <= regs_q[g] | hw_set[g];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Host mode edges: enable change and resume release.

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			host_on_prev_q <= 1'b0;
			resume_prev_q  <= 1'b0;
			host_rst_q     <= 1'b0;
			eop_q          <= 1'b0;
		end else begin
			host_on_prev_q <= regs_q[IDX_LINK][CTL_HOST_ON];
			resume_prev_q  <= regs_q[IDX_LINK][CTL_RESUME];
			host_rst_q     <= regs_q[IDX_LINK][CTL_HOST_ON] ^ host_on_prev_q;
			eop_q          <= resume_prev_q & ~regs_q[IDX_LINK][CTL_RESUME]
				& regs_q[IDX_LINK][CTL_HOST_ON];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign wb_ack_o   = ack_q;
	assign wb_dat_o   = dat_q;
	assign irq_o      = |(regs_q[IDX_OTG_IF] & regs_q[IDX_OTG_IE])
		| |(regs_q[IDX_BUS_IF] & regs_q[IDX_BUS_IE])
		| |(regs_q[IDX_ERR_IF] & regs_q[IDX_ERR_IE]);
	assign module_enable_o             = regs_q[IDX_LINK][CTL_ENABLE];
	assign ping_pong_reset_o           = regs_q[IDX_LINK][CTL_PPRST];
	assign resume_drive_o              = regs_q[IDX_LINK][CTL_RESUME];
	assign resume_eop_o                = eop_q;
	assign host_capability_enable_o    = regs_q[IDX_LINK][CTL_HOST_ON];
	assign host_logic_reset_o          = host_rst_q;
	assign bus_reset_drive_o           = regs_q[IDX_LINK][CTL_BUSRST]
		& regs_q[IDX_LINK][CTL_HOST_ON];
	assign packet_processing_disable_o = regs_q[IDX_LINK][CTL_PKT_HALT]
		& ~regs_q[IDX_LINK][CTL_HOST_ON];
	assign otg_pull_and_vbus_o         = regs_q[IDX_OTG_CON];
	assign power_control_o             = regs_q[IDX_PWR];
	assign function_address_o          = regs_q[IDX_FADDR];
	assign descriptor_page_o           = regs_q[IDX_BDT];
endmodule : uoc_ctrl

/* File: test/uoc_ctrl_asserts.sv */
/* Assertions on the uoc_ctrl ports.
 * Bound to every uoc_ctrl; one clock, synchronous active-high reset. */
`timescale 1ns/100ps
module uoc_ctrl_asserts (
	input wire logic                        clk_i,                         // Clock
	input wire logic                        rst_i,                         // Reset
	input wire logic                        wb_we_i,                       // Write
	input wire logic [uoc_pkg::UOC_ADDR_W-1:0] wb_adr_i,                   // Address
	input wire logic [31:0]                 wb_dat_o,                      // Read data
	input wire logic                        wb_ack_o,                      // Ack
	input wire logic                        live_j_line_flag_i,            // J
	input wire logic                        live_single_ended_zero_flag_i, // SE0
	input wire logic                        setup_token_i,                 // SETUP
	input wire logic                        host_capability_enable_o,      // Host
	input wire logic                        host_logic_reset_o,            // Host reset
	input wire logic                        bus_reset_drive_o,             // Bus reset
	input wire logic                        packet_processing_disable_o,   // Halt
	input wire logic                        resume_drive_o,                // Resume
	input wire logic                        resume_eop_o                   // EOP
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper bits read nonzero");
	j_flag_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 16'h5250
		|-> wb_dat_o[7] == $past(live_j_line_flag_i)) else $error("J flag wrong");
	se0_flag_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 16'h5250
		|-> wb_dat_o[6] == $past(live_single_ended_zero_flag_i)) else $error("SE0 wrong");
	setup_halt_a: assert property (setup_token_i && !host_capability_enable_o && !wb_ack_o
		|=> packet_processing_disable_o) else $error("SETUP did not halt");
	reset_host_a: assert property (bus_reset_drive_o |-> host_capability_enable_o)
		else $error("bus reset outside host mode");
	reset_cause_a: assert property ($rose(bus_reset_drive_o) |-> $past(wb_ack_o && wb_we_i))
		else $error("bus reset without a write");
	host_clear_a: assert property (!$past(rst_i) && $changed(host_capability_enable_o)
		|-> ##[1:2] host_logic_reset_o) else $error("no host logic reset");
	eop_end_a: assert property (!$past(rst_i) && $fell(resume_drive_o) && host_capability_enable_o
		|-> ##[1:2] resume_eop_o) else $error("no EOP after resume");
	xstat_alias_a: assert property (wb_ack_o && !$past(wb_we_i)
		&& $past(wb_adr_i) inside {16'h5244, 16'h5248, 16'h524c} |-> wb_dat_o == 32'h0)
		else $error("status alias decoded");
	cover property (host_logic_reset_o);
	cover property (resume_eop_o);
	cover property (packet_processing_disable_o);
endmodule : uoc_ctrl_asserts
bind uoc_ctrl uoc_ctrl_asserts i_asserts (
	.clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .live_j_line_flag_i,
	.live_single_ended_zero_flag_i, .setup_token_i, .host_capability_enable_o,
	.host_logic_reset_o, .bus_reset_drive_o, .packet_processing_disable_o,
	.resume_drive_o, .resume_eop_o);

/* File: test/uoc_line_model.sv */
/* Cable partner model: live line state, SETUP tokens and token busy.
 * Commanded by the bench on the bus clock. */
`timescale 1ns/100ps
module uoc_line_model (
	input  wire logic clk_i,          // Bus clock
	input  wire logic setup_i,        // Send a SETUP
	input  wire logic busy_i,         // Hold a token busy
	output logic      j_o     = 1'b0, // Receiver sees J
	output logic      se0_o   = 1'b0, // Both lines low
	output logic      setup_o = 1'b0, // SETUP pulse
	output logic      busy_o  = 1'b0  // Token busy
);
	// A fresh line state every cycle, so a stale capture shows.
	always @(posedge clk_i) begin
		{j_o, se0_o} <= 2'(3'h4 >> $urandom_range(2));
		setup_o      <= setup_i;
		busy_o       <= busy_i;
	end
endmodule : uoc_line_model

/* File: test/test_usb_otg_control_status.sv */
/* Bench for uoc_ctrl: register traffic, events and a cable partner.
 * The driver queues expected reads; a monitor compares them on ack. */
`timescale 1ns/100ps
module test_usb_otg_control_status;
	import uoc_pkg::*;
	logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic        suspend_busy_i = 0, activity_i = 0, st_req = 0, bz_req = 0;
	logic        setup_token_i, token_in_execution_i, live_j_line_flag_i, wb_ack_o, irq_o;
	logic        live_single_ended_zero_flag_i, module_enable_o, ping_pong_reset_o;
	logic        resume_drive_o, resume_eop_o, host_capability_enable_o, host_logic_reset_o;
	logic        bus_reset_drive_o, packet_processing_disable_o;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [15:0] wb_adr_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, r;
	logic [7:0]  otg_line_state_i = 0, otg_event_i = 0, bus_event_i = 0, bus_error_event_i = 0;
	logic [7:0]  transfer_status_i = 0, otg_pull_and_vbus_o, power_control_o;
	logic [7:0]  function_address_o, descriptor_page_o;
	logic [63:0] n, exp_q [$];
	int          failures = 0, num_checks = 0, tick = 0, c;
	uoc_ctrl i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .live_j_line_flag_i, .live_single_ended_zero_flag_i,
		.setup_token_i, .token_in_execution_i, .otg_line_state_i, .otg_event_i, .bus_event_i,
		.bus_error_event_i, .transfer_status_i, .suspend_busy_i, .activity_i, .irq_o,
		.module_enable_o, .ping_pong_reset_o, .resume_drive_o, .resume_eop_o,
		.host_capability_enable_o, .host_logic_reset_o, .bus_reset_drive_o,
		.packet_processing_disable_o, .otg_pull_and_vbus_o, .power_control_o,
		.function_address_o, .descriptor_page_o);
	uoc_line_model i_line (.clk_i, .setup_i(st_req), .busy_i(bz_req), .j_o(live_j_line_flag_i),
		.se0_o(live_single_ended_zero_flag_i), .setup_o(setup_token_i),
		.busy_o(token_in_execution_i));
	always #20 clk_i = ~clk_i;
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// For a read, d is the expected value under mask m; a write uses m of zero.
	task bus(input logic [15:0] a, input logic w, input logic [31:0] d, input logic [31:0] m);
		exp_q.push_back({d & m, m});
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask : bus
	task pulses(input bit w, input int e);
		c = 0;
		repeat (4) begin
			@(negedge clk_i);
			c += ((w ? resume_eop_o : host_logic_reset_o) === 1'b1);
		end
		chk(w ? "eop pulses" : "host reset pulses", e, c);
	endtask : pulses
	task give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
			n = exp_q.pop_front();
			if (n[31:0] != 0) chk("read data", n[63:32], wb_dat_o & n[31:0]);
		end
		if (++tick == 3000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(19));
		r = $urandom | 32'h800000;
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		foreach (REG_OFS[i]) bus(REG_OFS[i], 0, 0, i == IDX_PWR ? ~32'h80 : i == IDX_LINK ? ~32'hc0 : ~32'h0);
		bus(16'h5250, 1, 32'hffffffc1, 0);
		bus(16'h5250, 0, 32'h01, ~32'hc0);
		chk("module enable", 1, module_enable_o);
		bus(16'h5258, 1, 32'h02, 0);
		@(negedge clk_i) chk("ping pong reset", 1, ping_pong_reset_o);
		bus(16'h5254, 1, 32'h02, 0);
		bus(16'h5070, 1, r, 0);
		bus(16'h5270, 1, r, 0);
		chk("pull control", r[7:0], otg_pull_and_vbus_o);
		@(negedge clk_i) chk("table page", r[7:0] & 8'hfe, descriptor_page_o);
		for (int k = 0; k < 4; k++) begin
			bus(16'h5260 + 16'(k * 4), 1, 32'h0f << k, 0);
			bus(16'h5260, 0, k == 0 ? 32'h0f : k == 1 ? 32'h01 : k == 2 ? 32'h3d : 32'h45, 32'hff);
		end
		chk("address out", 32'h45, function_address_o);
		wb_sel_i <= 4'he;
		bus(16'h5260, 1, 32'hff, 0);
		wb_sel_i <= 4'hf;
		bus(16'h5260, 0, 32'h45, 32'hff);
		$display("reset and alias tests done");
		@(posedge clk_i) {transfer_status_i, bus_error_event_i, bus_event_i, otg_event_i, activity_i, suspend_busy_i} <= {r, 2'b11};
		@(posedge clk_i) {bus_error_event_i, bus_event_i, otg_event_i, activity_i} <= 0;
		bus(16'h5040, 0, r[7:0] & 8'hfd, 32'hff);
		bus(16'h5200, 0, r[15:8], 32'hff);
		bus(16'h5080, 0, 32'h88, 32'h88);
		chk("power out", 32'h80, power_control_o);
		chk("irq idle", 0, irq_o);
		bus(16'h5230, 1, 32'h80, 0);
		@(negedge clk_i) chk("irq raised", 1, irq_o);
		bus(16'h5234, 1, 32'h80, 0);
		@(negedge clk_i) chk("irq masked", 0, irq_o);
		bus(16'h5238, 1, 32'h80, 0);
		bus(16'h5228, 1, 32'hff, 0);
		bus(16'h522c, 1, 32'hff, 0);
		bus(16'h5220, 0, r[23:16], 32'hff);
		bus(16'h5224, 1, 32'hff, 0);
		@(negedge clk_i) chk("irq cleared", 0, irq_o);
		for (int k = 0; k < 4; k++) bus(16'h5240 + 16'(k * 4), 0, k ? 0 : r[31:24], ~32'h0);
		@(posedge clk_i) st_req <= 1;
		@(posedge clk_i) st_req <= 0;
		bus(16'h5250, 0, 32'h21, 32'h3f);
		chk("packet disable", 1, packet_processing_disable_o);
		$display("event and device tests done");
		bus(16'h5258, 1, 32'h08, 0);
		pulses(0, 1);
		@(posedge clk_i) bz_req <= 1;
		bus(16'h5250, 0, 32'h29, 32'h3f);
		@(posedge clk_i) bz_req <= 0;
		bus(16'h5250, 0, 32'h09, 32'h3f);
		bus(16'h5258, 1, 32'h10, 0);
		@(negedge clk_i) chk("bus reset", 1, bus_reset_drive_o);
		bus(16'h5254, 1, 32'h10, 0);
		@(negedge clk_i) chk("bus reset end", 0, bus_reset_drive_o);
		// Resume is held only a few cycles; the real hold time is far beyond the run budget.
		bus(16'h5258, 1, 32'h04, 0);
		@(negedge clk_i) chk("resume", 1, resume_drive_o);
		bus(16'h5254, 1, 32'h04, 0);
		pulses(1, 1);
		bus(16'h5254, 1, 32'h08, 0);
		pulses(0, 1);
		bus(16'h5258, 1, 32'h04, 0);
		bus(16'h5254, 1, 32'h04, 0);
		pulses(1, 0);
		$display("host tests done");
		give_verdict();
	end
endmodule : test_usb_otg_control_status
